// [include/dual_timer_pkg.sv]
// Purpose: Shared constants for the cascadable dual 16-bit timer block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes:   Offsets are byte addresses; control fields follow one layout
package dual_timer_pkg;

	// ************************************************************
	// Register map (byte offsets)
	// ************************************************************
	localparam logic [7:0] OFF_LOWER_CTRL   = 8'h00;
	localparam logic [7:0] OFF_UPPER_CTRL   = 8'h04;
	localparam logic [7:0] OFF_LOWER_PERIOD = 8'h08;
	localparam logic [7:0] OFF_UPPER_PERIOD = 8'h0C;
	localparam logic [7:0] OFF_LOWER_COUNT  = 8'h10;
	localparam logic [7:0] OFF_UPPER_COUNT  = 8'h14;
	localparam logic [7:0] OFF_IRQ          = 8'h18;

	// ************************************************************
	// Control register fields
	// ************************************************************
	localparam int CTRL_PRESCALE_LSB = 0;
	localparam int CTRL_GATE_BIT     = 1 + 1;
	localparam int CTRL_CASCADE_BIT  = 3;
	localparam int CTRL_SOURCE_BIT   = 4;
	localparam int CTRL_ON_BIT       = 15;
	localparam logic [15:0] CTRL_WRITE_MASK = 16'h801F;

	// ************************************************************
	// Interrupt register fields: per timer enable, priority, flag
	// ************************************************************
	localparam int IRQ_LOWER_LSB   = 0;
	localparam int IRQ_UPPER_LSB   = 8;
	localparam int IRQ_EN_OFS      = 0;
	localparam int IRQ_PRIO_OFS    = 1;
	localparam int IRQ_FLAG_OFS    = 4;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [15:0] RESET_CTRL   = 16'h0000;
	localparam logic [15:0] RESET_PERIOD = 16'hFFFF;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : dual_timer_pkg

// [include/tick_if.sv]
// Purpose: Count-enable bundle from the tick source to the counter cores
// Assumes: Single clock domain
// Notes:   tick is a one-cycle enable pulse
`timescale 1ns/100ps
`default_nettype none
interface tick_if;
	logic tick;
	modport source (output tick);
	modport sink   (input  tick);
endinterface : tick_if
`default_nettype wire

// [rtl/tick_source.sv]
// Purpose: Builds a prescaled count enable from internal or external clock
// Assumes: ext_rise and gate_lvl are already synchronised; one clock domain
// Notes:   Prescale ratios 1, 8, 64, 256 selected by a 2-bit field
`timescale 1ns/100ps
`default_nettype none
module tick_source (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       run,
	input  wire logic [1:0] prescale,
	input  wire logic       use_ext,
	input  wire logic       gate_en,
	input  wire logic       ext_rise,
	input  wire logic       gate_lvl,
	tick_if.source          out
);
	logic [7:0] div_q;
	logic       raw;
	logic [7:0] limit;

	// Ratio table; gated mode counts internal clock while gate is high
	always_comb begin
		case (prescale)
			2'h0:    limit = 8'h00;
			2'h1:    limit = 8'h07;
			2'h2:    limit = 8'h3F;
			default: limit = 8'hFF;
		endcase
		if (gate_en && !use_ext)
			raw = gate_lvl;
		else if (use_ext)
			raw = ext_rise;
		else
			raw = 1'b1;
	end

	// Divider; held while stopped so each start begins a fresh ratio.
	// Compared with >= so a ratio lowered while running cannot strand it
	always_ff @(posedge clk) begin
		if (rst || !run)
			div_q <= 8'h00;
		else if (raw)
			div_q <= (div_q >= limit) ? 8'h00 : div_q + 8'h01;
	end

	assign out.tick = run && raw && (div_q >= limit);
endmodule : tick_source
`default_nettype wire

// [rtl/dual_timer.sv]
// Purpose: Pair of 16-bit timers, split or cascaded into one 32-bit timer
// Assumes: AXI4-Lite slave, 10 MHz clk, synchronous active-high reset
// Notes:   External clock and gate pins pass a three-stage synchroniser
//
// Functional notes
// - Pair runs as 32-bit or two 16-bit
// - Split timers count synchronously, timer or counter
// - Cascade offers 32-bit synchronous counter mode too
// - Gate, prescaler; keeps running in low power
// - Cascade interrupts on full 32-bit period match
// - Conversion trigger comes only from upper timer
// - Lower timer is low word, upper high
// - Cascade ignores upper control; lower controls all
// - Cascade uses lower clock and gate inputs
// - Cascade interrupt reported via upper flag, enable
// - Control bit 3 selects cascade when set
// - Two-bit prescale; lower field used in cascade
// - Source select and gate enable bits
// - Upper period high word, lower period low
// - Live count readable from count pair
// - Split timers compare against own period
// - Per-timer irq enable and 3-bit priority
// - Bit 15 starts the timer when set
//
// Local design decisions: the AXI4-Lite register port and the register offsets.
`timescale 1ns/100ps
`default_nettype none
module dual_timer (
	input  wire logic        clk,
	input  wire logic        rst,
	// AXI4-Lite slave
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Pins
	input  wire logic        lower_ext_clk,
	input  wire logic        lower_gate,
	input  wire logic        upper_ext_clk,
	input  wire logic        upper_gate,
	output logic             lower_irq,
	output logic             upper_irq,
	output logic [2:0]       lower_irq_priority,
	output logic [2:0]       upper_irq_priority,
	output logic             adc_trigger
);
	// ************************************************************
	// Registers and state
	// ************************************************************
	logic [15:0] lower_timer_control_q;
	logic [15:0] upper_timer_control_q;
	logic [15:0] lower_period_q;
	logic [15:0] upper_period_q;
	logic [15:0] lower_count_q;
	logic [15:0] upper_count_q;
	logic        lower_irq_enable_q;
	logic        upper_irq_enable_q;
	logic [2:0]  lower_prio_q;
	logic [2:0]  upper_prio_q;
	logic        lower_flag_q;
	logic        upper_flag_q;

	// ************************************************************
	// Pin synchronisers: change taken once stages two and three agree
	// ************************************************************
	logic [2:0] sync_q [4];
	logic [3:0] pin_now;
	logic [3:0] pin_q;
	logic [3:0] pin_prev_q;
	assign pin_now = {upper_gate, upper_ext_clk, lower_gate, lower_ext_clk};

	// Three flops per pin
	always_ff @(posedge clk) begin
		for (int i = 0; i < 4; i++) begin
			if (rst)
				sync_q[i] <= 3'h0;
			else
				sync_q[i] <= {sync_q[i][1:0], pin_now[i]};
		end
	end

	// Filtered level updates only when the later two stages agree
	always_ff @(posedge clk) begin
		if (rst) begin
			pin_q      <= 4'h0;
			pin_prev_q <= 4'h0;
		end else begin
			pin_prev_q <= pin_q;
			for (int i = 0; i < 4; i++) begin
				if (sync_q[i][1] == sync_q[i][2])
					pin_q[i] <= sync_q[i][2];
			end
		end
	end

	// ************************************************************
	// Mode decode
	// ************************************************************
	logic cascade;
	logic lower_on;
	logic upper_on;
	assign cascade  = lower_timer_control_q[dual_timer_pkg::CTRL_CASCADE_BIT];
	assign lower_on = lower_timer_control_q[dual_timer_pkg::CTRL_ON_BIT];
	// Upper control is ignored while cascaded
	assign upper_on = !cascade &&
		upper_timer_control_q[dual_timer_pkg::CTRL_ON_BIT];

	function automatic logic [1:0] prescale_of(input logic [15:0] ctrl);
		prescale_of = ctrl[dual_timer_pkg::CTRL_PRESCALE_LSB +: 2];
	endfunction : prescale_of

	// ************************************************************
	// Tick sources; lower one also drives the cascaded pair
	// ************************************************************
	tick_if lower_tick ();
	tick_if upper_tick ();

	tick_source u_lower_tick (
		.clk      (clk),
		.rst      (rst),
		.run      (lower_on),
		.prescale (prescale_of(lower_timer_control_q)),
		.use_ext  (lower_timer_control_q[dual_timer_pkg::CTRL_SOURCE_BIT]),
		.gate_en  (lower_timer_control_q[dual_timer_pkg::CTRL_GATE_BIT]),
		.ext_rise (pin_q[0] && !pin_prev_q[0]),
		.gate_lvl (pin_q[1]),
		.out      (lower_tick)
	);

	tick_source u_upper_tick (
		.clk      (clk),
		.rst      (rst),
		.run      (upper_on),
		.prescale (prescale_of(upper_timer_control_q)),
		.use_ext  (upper_timer_control_q[dual_timer_pkg::CTRL_SOURCE_BIT]),
		.gate_en  (upper_timer_control_q[dual_timer_pkg::CTRL_GATE_BIT]),
		.ext_rise (pin_q[2] && !pin_prev_q[2]),
		.gate_lvl (pin_q[3]),
		.out      (upper_tick)
	);

	// ************************************************************
	// Period match
	// ************************************************************
	logic lower_match;
	logic upper_match;
	logic pair_match;
	assign lower_match = (lower_count_q == lower_period_q);
	assign upper_match = (upper_count_q == upper_period_q);
	assign pair_match  = lower_match && upper_match;

	logic lower_event;
	logic upper_event;
	assign lower_event = cascade ? 1'b0 : lower_tick.tick && lower_match;
	assign upper_event = cascade ? lower_tick.tick && pair_match
		: upper_tick.tick && upper_match;

	// ************************************************************
	// Bus write channel
	// ************************************************************
	logic [7:0]  aw_q;
	logic        aw_have_q;
	logic [31:0] w_q;
	logic [3:0]  ws_q;
	logic        w_have_q;
	logic        do_write;
	assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

	// Address and data accepted in either order, response after both
	always_ff @(posedge clk) begin
		if (rst) begin
			aw_have_q    <= 1'b0;
			w_have_q     <= 1'b0;
			aw_q         <= 8'h00;
			w_q          <= 32'h0000_0000;
			ws_q         <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= dual_timer_pkg::RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q <= 1'b1;
				aw_q      <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q <= 1'b1;
				w_q      <= s_axi_wdata;
				ws_q     <= s_axi_wstrb;
			end
			if (do_write) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= addr_ok(aw_q) ? dual_timer_pkg::RESP_OKAY
					: dual_timer_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Ready low while a word is held; one write at a time
	assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
	assign s_axi_wready  = !w_have_q && !s_axi_bvalid;

	function automatic logic addr_ok(input logic [7:0] a);
		addr_ok = (a[1:0] == 2'h0) && (a <= dual_timer_pkg::OFF_IRQ);
	endfunction : addr_ok

	function automatic logic [15:0] merge16(input logic [15:0] old,
		input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction : merge16

	logic wr_lctl;
	logic wr_uctl;
	logic wr_lper;
	logic wr_uper;
	logic wr_lcnt;
	logic wr_ucnt;
	logic wr_irq;
	assign wr_lctl = do_write && aw_q == dual_timer_pkg::OFF_LOWER_CTRL;
	assign wr_uctl = do_write && aw_q == dual_timer_pkg::OFF_UPPER_CTRL;
	assign wr_lper = do_write && aw_q == dual_timer_pkg::OFF_LOWER_PERIOD;
	assign wr_uper = do_write && aw_q == dual_timer_pkg::OFF_UPPER_PERIOD;
	assign wr_lcnt = do_write && aw_q == dual_timer_pkg::OFF_LOWER_COUNT;
	assign wr_ucnt = do_write && aw_q == dual_timer_pkg::OFF_UPPER_COUNT;
	assign wr_irq  = do_write && aw_q == dual_timer_pkg::OFF_IRQ;

	// ************************************************************
	// Control and period registers
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			lower_timer_control_q <= dual_timer_pkg::RESET_CTRL;
			upper_timer_control_q <= dual_timer_pkg::RESET_CTRL;
			lower_period_q        <= dual_timer_pkg::RESET_PERIOD;
			upper_period_q        <= dual_timer_pkg::RESET_PERIOD;
		end else begin
			if (wr_lctl)
				lower_timer_control_q <= merge16(lower_timer_control_q,
					w_q, ws_q) & dual_timer_pkg::CTRL_WRITE_MASK;
			// Upper copy keeps its cascade bit clear; only the lower decides
			if (wr_uctl)
				upper_timer_control_q <= merge16(upper_timer_control_q,
					w_q, ws_q) & dual_timer_pkg::CTRL_WRITE_MASK
					& ~(16'h0001 << dual_timer_pkg::CTRL_CASCADE_BIT);
			if (wr_lper)
				lower_period_q <= merge16(lower_period_q, w_q, ws_q);
			if (wr_uper)
				upper_period_q <= merge16(upper_period_q, w_q, ws_q);
		end
	end

	// ************************************************************
	// Counters: count written by software takes priority over a tick
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			lower_count_q <= 16'h0000;
		end else if (wr_lcnt) begin
			lower_count_q <= merge16(lower_count_q, w_q, ws_q);
		end else if (lower_tick.tick) begin
			if (cascade ? pair_match : lower_match)
				lower_count_q <= 16'h0000;
			else
				lower_count_q <= lower_count_q + 16'h0001;
		end
	end

	// Upper word: carry from lower when cascaded, own tick otherwise
	always_ff @(posedge clk) begin
		if (rst) begin
			upper_count_q <= 16'h0000;
		end else if (wr_ucnt) begin
			upper_count_q <= merge16(upper_count_q, w_q, ws_q);
		end else if (cascade) begin
			if (lower_tick.tick && pair_match)
				upper_count_q <= 16'h0000;
			else if (lower_tick.tick && lower_count_q == 16'hFFFF)
				upper_count_q <= upper_count_q + 16'h0001;
		end else if (upper_tick.tick) begin
			if (upper_match)
				upper_count_q <= 16'h0000;
			else
				upper_count_q <= upper_count_q + 16'h0001;
		end
	end

	// ************************************************************
	// Interrupt enables, priorities, flags (set wins over clear)
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			lower_irq_enable_q <= 1'b0;
			upper_irq_enable_q <= 1'b0;
			lower_prio_q       <= 3'h0;
			upper_prio_q       <= 3'h0;
		end else if (wr_irq) begin
			if (ws_q[0]) begin
				lower_irq_enable_q <= w_q[dual_timer_pkg::IRQ_LOWER_LSB
					+ dual_timer_pkg::IRQ_EN_OFS];
				lower_prio_q <= w_q[dual_timer_pkg::IRQ_LOWER_LSB
					+ dual_timer_pkg::IRQ_PRIO_OFS +: 3];
			end
			if (ws_q[1]) begin
				upper_irq_enable_q <= w_q[dual_timer_pkg::IRQ_UPPER_LSB
					+ dual_timer_pkg::IRQ_EN_OFS];
				upper_prio_q <= w_q[dual_timer_pkg::IRQ_UPPER_LSB
					+ dual_timer_pkg::IRQ_PRIO_OFS +: 3];
			end
		end
	end

	// Writing 1 to a flag position clears it
	always_ff @(posedge clk) begin
		if (rst) begin
			lower_flag_q <= 1'b0;
			upper_flag_q <= 1'b0;
		end else begin
			if (lower_event)
				lower_flag_q <= 1'b1;
			else if (wr_irq && ws_q[0] && w_q[dual_timer_pkg::IRQ_LOWER_LSB
				+ dual_timer_pkg::IRQ_FLAG_OFS])
				lower_flag_q <= 1'b0;
			if (upper_event)
				upper_flag_q <= 1'b1;
			else if (wr_irq && ws_q[1] && w_q[dual_timer_pkg::IRQ_UPPER_LSB
				+ dual_timer_pkg::IRQ_FLAG_OFS])
				upper_flag_q <= 1'b0;
		end
	end

	// ************************************************************
	// Outputs, all registered
	// ************************************************************
	always_ff @(posedge clk) begin
		if (rst) begin
			lower_irq          <= 1'b0;
			upper_irq          <= 1'b0;
			lower_irq_priority <= 3'h0;
			upper_irq_priority <= 3'h0;
			adc_trigger        <= 1'b0;
		end else begin
			lower_irq          <= lower_flag_q && lower_irq_enable_q;
			upper_irq          <= upper_flag_q && upper_irq_enable_q;
			lower_irq_priority <= lower_prio_q;
			upper_irq_priority <= upper_prio_q;
			adc_trigger        <= upper_event;
		end
	end

	// ************************************************************
	// Bus read channel, one cycle after the address is taken
	// ************************************************************
	logic [31:0] rd_word;
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			dual_timer_pkg::OFF_LOWER_CTRL:   rd_word[15:0] = lower_timer_control_q;
			dual_timer_pkg::OFF_UPPER_CTRL:   rd_word[15:0] = upper_timer_control_q;
			dual_timer_pkg::OFF_LOWER_PERIOD: rd_word[15:0] = lower_period_q;
			dual_timer_pkg::OFF_UPPER_PERIOD: rd_word[15:0] = upper_period_q;
			dual_timer_pkg::OFF_LOWER_COUNT:  rd_word[15:0] = lower_count_q;
			dual_timer_pkg::OFF_UPPER_COUNT:  rd_word[15:0] = upper_count_q;
			dual_timer_pkg::OFF_IRQ: rd_word[15:0] = {3'h0, upper_flag_q,
				upper_prio_q, upper_irq_enable_q, 3'h0, lower_flag_q,
				lower_prio_q, lower_irq_enable_q};
			default:                          rd_word = 32'h0000_0000;
		endcase
	end

	assign s_axi_arready = !s_axi_rvalid;

	always_ff @(posedge clk) begin
		if (rst) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= dual_timer_pkg::RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_word;
			s_axi_rresp  <= addr_ok(s_axi_araddr) ? dual_timer_pkg::RESP_OKAY
				: dual_timer_pkg::RESP_SLVERR;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : dual_timer
`default_nettype wire

// [sim/dual_timer_monitor.sv]
// Purpose: Port checks for the dual timer
// Assumes: One clock, synchronous active-high rst
// Notes:   Bound from the bench top file
`timescale 1ns/100ps
`default_nettype none
module dual_timer_monitor (
	input wire logic        clk,
	input wire logic        rst,
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic [1:0]  s_axi_bresp,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready,
	input wire logic        lower_irq,
	input wire logic        adc_trigger
);
	// ****
	// Bus handshakes and events
	// ****
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);

	// Reset must leave answers idle; it is checked during reset itself
	AST_RESET_IDLE: assert property (disable iff (1'b0)
		rst |=> s_axi_awready && s_axi_arready && !s_axi_bvalid
			&& !s_axi_rvalid && !lower_irq && !adc_trigger)
		else $error("outputs not idle after reset");
	AST_B_HOLD: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped early");
	AST_R_HOLD: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
			&& $stable(s_axi_rdata) && $stable(s_axi_rresp))
		else $error("read data dropped early");
	AST_R_ANSWER: assert property (
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
	AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while answer pending");
	AST_W_REFUSE: assert property (
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	AST_B_ANSWER: assert property (
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
			|-> ##[1:3] s_axi_bvalid)
		else $error("write answer late");
	AST_ERR_ZERO: assert property (
		s_axi_rvalid && s_axi_rresp == dual_timer_pkg::RESP_SLVERR
			|-> s_axi_rdata == 32'h0)
		else $error("refused read returned data");
	AST_RESP_CODE: assert property (
		s_axi_bvalid |-> s_axi_bresp == dual_timer_pkg::RESP_OKAY
			|| s_axi_bresp == dual_timer_pkg::RESP_SLVERR)
		else $error("bad write response code");
endmodule : dual_timer_monitor
`default_nettype wire

// [sim/dual_timer_bench.sv]
// Purpose: Self-checking bench for the dual timer
// Assumes: 10 MHz clock, reset held three cycles
// Notes:   Answers are sampled on the falling edge to stay race free
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin bad_count++; \
	$display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module dual_timer_bench;
	// ****
	// Signals and instance
	// ****
	localparam logic [7:0] LC = dual_timer_pkg::OFF_LOWER_CTRL;
	localparam logic [7:0] UC = dual_timer_pkg::OFF_UPPER_CTRL;
	localparam logic [7:0] LP = dual_timer_pkg::OFF_LOWER_PERIOD;
	localparam logic [7:0] UP = dual_timer_pkg::OFF_UPPER_PERIOD;
	localparam logic [7:0] LN = dual_timer_pkg::OFF_LOWER_COUNT;
	localparam logic [7:0] UN = dual_timer_pkg::OFF_UPPER_COUNT;
	localparam logic [7:0] IQ = dual_timer_pkg::OFF_IRQ;
	logic        clk, rst, awvalid, wvalid, bready, arvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic        lo_ck, lo_gt, up_ck, up_gt, awready, wready, bvalid;
	logic        arready, rvalid, lo_irq, up_irq, adc;
	logic [1:0]  bresp, rresp;
	logic [2:0]  lo_pri, up_pri;
	int          bad_count = 0;
	int          checked = 0;
	int          trig_n = 0;

	dual_timer dut_u (
		.clk(clk), .rst(rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.lower_ext_clk(lo_ck), .lower_gate(lo_gt), .upper_ext_clk(up_ck),
		.upper_gate(up_gt), .lower_irq(lo_irq), .upper_irq(up_irq),
		.lower_irq_priority(lo_pri), .upper_irq_priority(up_pri),
		.adc_trigger(adc));

	// Free-running 100 ns clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	// Trigger pulses are tallied so tests compare counts, not moments
	always @(posedge clk) begin
		if (adc === 1'b1) trig_n++;
	end

	// ****
	// Bus tasks and helpers
	// ****
	task automatic finish_test;
		$display("counts: %0d checked, %0d wrong", checked, bad_count);
		if (bad_count == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	task automatic hang;
		bad_count++;
		$display("timeout at %0t", $time);
		finish_test;
	endtask : hang

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		output logic [1:0] r);
		int   n;
		logic aw, wd, ta, tw;
		n = 0;
		aw = 1'b1;
		wd = 1'b1;
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		// Address and data may be taken on different edges
		while ((aw || wd) && n < 200) begin
			@(negedge clk);
			ta = aw && awready === 1'b1;
			tw = wd && wready === 1'b1;
			@(posedge clk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
			aw = aw && !ta;
			wd = wd && !tw;
			n++;
		end
		do begin @(negedge clk); n++; end while (bvalid !== 1'b1 && n < 200);
		// Ready comes late so the held response is also checked
		@(posedge clk);
		bready <= 1'b1;
		@(negedge clk);
		r = bresp;
		@(posedge clk);
		bready <= 1'b0;
		if (n >= 200) hang;
	endtask : wr

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		int n;
		n = 0;
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin @(negedge clk); n++; end while (arready !== 1'b1 && n < 200);
		@(posedge clk);
		arvalid <= 1'b0;
		do begin @(negedge clk); n++; end while (rvalid !== 1'b1 && n < 200);
		// Ready comes late so the held read data is also checked
		@(posedge clk);
		rready <= 1'b1;
		@(negedge clk);
		d = rdata;
		r = rresp;
		@(posedge clk);
		rready <= 1'b0;
		if (n >= 200) hang;
	endtask : rd

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		wr(a, d, r);
	endtask : w

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		`CHK(d, e)
	endtask : rc

	task automatic settle(input int n);
		repeat (n) @(negedge clk);
	endtask : settle

	function automatic int ratio(input int s);
		return (s == 3) ? 256 : 1 << (3 * s);
	endfunction : ratio

	// ****
	// Main sequence
	// ****
	initial begin
		logic [31:0] d, e, pr;
		logic [1:0]  r;
		int          p, q, k, t0;
		{awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
		{lo_ck, lo_gt, up_ck, up_gt} = 4'h0;
		wstrb = 4'hF;
		rst = 1'b1;
		p = $urandom(18698);
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		// Reset values, then refused and misaligned accesses
		rc(LC, 32'h0);
		rc(UC, 32'h0);
		rc(LP, 32'hFFFF);
		rc(UP, 32'hFFFF);
		rc(LN, 32'h0);
		rc(UN, 32'h0);
		rc(IQ, 32'h0);
		rd(8'h1C, d, r);
		`CHK(r, dual_timer_pkg::RESP_SLVERR)
		wr(8'h02, 32'hFFFF, r);
		`CHK(r, dual_timer_pkg::RESP_SLVERR)
		rc(LC, 32'h0);
		$display("test reset finished");
		// Control fields; cascade bit lives only in the lower control
		for (k = 0; k < 8; k++) begin
			d = $urandom & 32'h7FFF;
			w(LC, d);
			rc(LC, d & 32'h001F);
			w(UC, d);
			rc(UC, d & 32'h0017);
		end
		w(LC, 32'hFFFF);
		rc(LC, 32'h801F);
		w(LC, 32'h0);
		$display("test control finished");
		// Each prescale ratio, then the count holds once stopped
		for (k = 0; k < 4; k++) begin
			w(LN, 32'h0);
			w(LC, 32'h8000 | k);
			settle(512);
			w(LC, 32'h0);
			rd(LN, d, r);
			e = 512 / ratio(k);
			`CHK(d + 1 >= e && d <= e + 12, 1'b1)
			settle(40);
			rc(LN, d);
		end
		$display("test prescale finished");
		// Split timers with random short periods and priorities
		p = 3 + $urandom % 13;
		q = 3 + $urandom % 13;
		k = $urandom % 8;
		pr = 32'(k << 1 | (7 - k) << 9);
		w(LP, p);
		w(UP, q);
		w(IQ, 32'h0101 | pr);
		settle(2);
		`CHK(lo_pri, k[2:0])
		`CHK(up_pri, 3'(7 - k))
		t0 = trig_n;
		w(LC, 32'h8000);
		repeat (8) begin rd(LN, d, r); `CHK(d <= p, 1'b1) end
		w(LC, 32'h0);
		settle(2);
		`CHK(trig_n, t0)
		`CHK(lo_irq, 1'b1)
		rc(IQ, 32'h0111 | pr);
		w(IQ, 32'h0100 | pr);
		settle(2);
		`CHK(lo_irq, 1'b0)
		w(IQ, 32'h0110 | pr);
		rc(IQ, 32'h0100 | pr);
		t0 = trig_n;
		w(UC, 32'h8000);
		settle(200);
		w(UC, 32'h0);
		settle(2);
		e = 200 / (q + 1);
		`CHK(trig_n - t0 + 1 >= e && trig_n - t0 <= e + 1, 1'b1)
		`CHK(up_irq, 1'b1)
		$display("test split finished");
		// Cascade: only the full 32-bit match may wrap and trigger
		w(IQ, 32'h1111);
		w(LP, 32'h0);
		w(UP, 32'h1);
		w(LN, 32'hFFFF);
		w(UN, 32'h0);
		w(UC, 32'h8003);
		t0 = trig_n;
		w(LC, 32'h800A);
		for (k = 0; k < 60; k++) begin
			rd(UN, d, r);
			if (d === 32'h1) break;
		end
		`CHK(d, 32'h1)
		rc(LN, 32'h0);
		settle(300);
		`CHK(trig_n - t0, 1)
		`CHK(up_irq, 1'b1)
		`CHK(lo_irq, 1'b0)
		w(LC, 32'h0);
		rc(UN, 32'h0);
		rc(IQ, 32'h1101);
		$display("test cascade finished");
		// Gated accumulation, then external clock edges
		w(LP, 32'hFFFF);
		w(LN, 32'h0);
		w(LC, 32'h8004);
		settle(50);
		rc(LN, 32'h0);
		@(posedge clk) lo_gt <= 1'b1;
		repeat (100) @(posedge clk);
		lo_gt <= 1'b0;
		settle(20);
		rd(LN, d, r);
		`CHK(d >= 96 && d <= 104, 1'b1)
		w(LC, 32'h0);
		w(LN, 32'h0);
		// Upper split timer on its own pin, counted alongside
		w(UP, 32'hFFFF);
		w(UC, 32'h8010);
		w(UN, 32'h0);
		w(LC, 32'h8010);
		repeat (10) begin
			repeat (6) @(posedge clk);
			lo_ck <= 1'b1;
			up_ck <= 1'b1;
			repeat (6) @(posedge clk);
			lo_ck <= 1'b0;
			up_ck <= 1'b0;
		end
		settle(20);
		rc(LN, 32'hA);
		rc(UN, 32'hA);
		$display("test gate and source finished");
		finish_test;
	end
endmodule : dual_timer_bench

bind dual_timer dual_timer_monitor mon_u (.clk(clk), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
	.s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .lower_irq(lower_irq),
	.adc_trigger(adc_trigger));
`default_nettype wire
